// ### rtl/pin_sync.sv
// Two-stage synchroniser for a bundle of asynchronous pins.
// Assumes the pins are levels; edges are found downstream.
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // Pins in, synchronised levels out
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] pin_sync_out
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } sync_state_t;

  sync_state_t state_ff;
  sync_state_t nxt_state;

  always_comb begin
    nxt_state.meta = pin_in;
    nxt_state.stable = state_ff.meta;
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign pin_sync_out = state_ff.stable;
endmodule

// ### rtl/pll_aux_pfd.sv
// Auxiliary control register, monitor mux, phase-frequency detector and lock flag.
// Assumes serial pins, divided pulses and gate come from outside the sys_clk domain.
`timescale 1ns/1ps
module pll_aux_pfd (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // Serial programming pins
  input wire logic ser_clk,
  input wire logic ser_data,
  input wire logic aux_wr,
  input wire logic main_wr,
  input wire logic aux_gate_n,
  // Divider chain inputs
  input wire logic vco_div_pulse,
  input wire logic ref_div_pulse,
  input wire logic modulus_select,
  // Control outputs
  output logic monitor_out,
  output logic power_down,
  output logic counter_load,
  // Detector and charge pump
  output logic pump_up_n,
  output logic pump_down_n,
  output logic pump_source,
  output logic pump_sink,
  output logic lock_node,
  output logic lock_flag
);
  localparam int NPIN = 8;

  // Detector states
  typedef enum logic [1:0] {
    PFD_IDLE,
    PFD_UP,
    PFD_DOWN
  } pfd_state_t;

  typedef struct packed {
    logic [7:0] shift;
    logic [7:0] hold;
    logic sclk_d;
    logic awr_d;
    logic vco_d;
    logic ref_d;
    pfd_state_t pfd;
    logic [3:0] lock_cnt;
    logic lock;
    logic mon;
    logic pd;
    logic load;
  } aux_state_t;

  aux_state_t state_ff;
  aux_state_t nxt_state;
  logic [NPIN-1:0] pins_s;
  logic s_clk, s_data, s_awr, s_mwr, s_gate_n, s_vco, s_ref, s_modulus_select;
  logic [7:0] eff;
  logic sclk_rise, awr_fall, vco_rise, ref_rise, node;
  logic up_act, dn_act;

  // Rising edge of a synchronised level
  function automatic logic rose(input logic now, input logic prev);
    return now && !prev;
  endfunction

  // Control bits in force under the gate pin
  function automatic logic [7:0] gated(input logic gate_n, input logic [7:0] bits);
    return gate_n ? 8'h00 : bits;
  endfunction

  pin_sync #(
    .WIDTH(NPIN)
  ) u_sync (
    .sys_clk(sys_clk),
    .srst(srst),
    .pin_in({ser_clk, ser_data, aux_wr, main_wr, aux_gate_n, vco_div_pulse, ref_div_pulse, modulus_select}),
    .pin_sync_out(pins_s)
  );

  assign {s_clk, s_data, s_awr, s_mwr, s_gate_n, s_vco, s_ref, s_modulus_select} = pins_s;

  // Detector state decoded once for the pump pins
  assign up_act = (state_ff.pfd == PFD_UP);
  assign dn_act = (state_ff.pfd == PFD_DOWN);

  always_comb begin
    nxt_state = state_ff;
    nxt_state.sclk_d = s_clk;
    nxt_state.awr_d = s_awr;
    nxt_state.vco_d = s_vco;
    nxt_state.ref_d = s_ref;
    sclk_rise = rose(s_clk, state_ff.sclk_d);
    awr_fall = rose(!s_awr, !state_ff.awr_d);

    // serial shift in
    // First bit ends in bit 0 after eight shifts
    if (sclk_rise && s_awr && !s_mwr) begin
      nxt_state.shift = {s_data, state_ff.shift[7:1]};
    end

    if (awr_fall) begin
      nxt_state.hold = state_ff.shift;
    end

    eff = gated(s_gate_n, state_ff.hold);

    nxt_state.pd = eff[pll_ctl_pkg::BIT_POWER_DOWN];
    nxt_state.load = eff[pll_ctl_pkg::BIT_COUNTER_LOAD] && !eff[pll_ctl_pkg::BIT_POWER_DOWN];

    vco_rise = rose(s_vco, state_ff.vco_d);
    ref_rise = rose(s_ref, state_ff.ref_d);

    if (eff[pll_ctl_pkg::BIT_POWER_DOWN]) begin
      nxt_state.pfd = PFD_IDLE;
    end else begin
      unique case (state_ff.pfd)
        PFD_IDLE: begin
          if (vco_rise && !ref_rise) begin
            nxt_state.pfd = PFD_DOWN;
          end else if (ref_rise && !vco_rise) begin
            nxt_state.pfd = PFD_UP;
          end
        end
        PFD_UP: begin
          if (vco_rise) begin
            nxt_state.pfd = PFD_IDLE;
          end
        end
        PFD_DOWN: begin
          if (ref_rise) begin
            nxt_state.pfd = PFD_IDLE;
          end
        end
        default: begin
          nxt_state.pfd = PFD_IDLE;
        end
      endcase
    end

    node = !(!up_act && !dn_act);

    // filtered inverted lock
    // Sixteen quiet cycles before lock
    if (node) begin
      nxt_state.lock_cnt = '0;
      nxt_state.lock = 1'b0;
    end else if (state_ff.lock_cnt != pll_ctl_pkg::LOCK_FILTER_MAX) begin
      nxt_state.lock_cnt = state_ff.lock_cnt + 4'h1;
    end else begin
      nxt_state.lock = 1'b1;
    end

    if (eff[pll_ctl_pkg::BIT_POWER_DOWN]) begin
      nxt_state.mon = 1'b0;
    end else if (eff[pll_ctl_pkg::BIT_VCO_MON]) begin
      nxt_state.mon = s_vco;
    end else if (eff[pll_ctl_pkg::BIT_MODSEL_MON]) begin
      nxt_state.mon = s_modulus_select;
    end else if (eff[pll_ctl_pkg::BIT_REF_MON]) begin
      nxt_state.mon = s_ref;
    end else begin
      nxt_state.mon = 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state_ff <= '0;
      state_ff.shift <= pll_ctl_pkg::AUX_RESET;
      state_ff.hold <= pll_ctl_pkg::AUX_RESET;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign monitor_out = state_ff.mon;
  assign power_down = state_ff.pd;
  assign counter_load = state_ff.load;
  assign pump_up_n = !up_act;
  assign pump_down_n = !dn_act;
  assign pump_source = up_act;
  assign pump_sink = dn_act;
  assign lock_node = !(pump_up_n && pump_down_n);
  assign lock_flag = state_ff.lock;
endmodule

// ### rtl/pll_ctl_pkg.sv
// Package for the synthesizer auxiliary control and phase detector block.
// Assumes a single sys_clk domain; all pins arrive asynchronously.
package pll_ctl_pkg;
  localparam int AUX_WIDTH = 8;
  localparam logic [7:0] AUX_RESET = 8'h00;
  localparam int BIT_VCO_MON = 2;
  localparam int BIT_POWER_DOWN = 3;
  localparam int BIT_COUNTER_LOAD = 4;
  localparam int BIT_MODSEL_MON = 5;
  localparam int BIT_REF_MON = 6;
  localparam int SYNC_STAGES = 2;
  localparam int LOCK_FILTER_WIDTH = 4;
  localparam logic [3:0] LOCK_FILTER_MAX = 4'hf;
endpackage

// ### test/host_model.sv
// Host driving the three-wire serial port.
// Assumes ser_clk stands low outside frames.
`timescale 1ns/1ps
module host_model (
  // Serial pins
  output logic ser_clk,
  output logic ser_data,
  output logic aux_wr
);
  initial begin
    ser_clk = 0;
    ser_data = 0;
    aux_wr = 0;
  end
  task automatic send(input logic [7:0] v);
    aux_wr <= 1'b1;
    #80;
    for (int i = 0; i < 8; i++) begin
      ser_data <= v[i];
      #80 ser_clk <= 1'b1;
      #80 ser_clk <= 1'b0;
    end
    #80 aux_wr <= 1'b0;
    ser_data <= ~v[7];
    #400;
  endtask
endmodule

// ### test/pll_aux_pfd_chk.sv
// Checker for the aux control and detector outputs.
// Assumes binding onto pll_aux_pfd, one sys_clk domain.
`timescale 1ns/1ps
module pll_aux_pfd_chk (
  // Clock, reset, gate
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic aux_gate_n,
  // Observed outputs
  input wire logic monitor_out,
  input wire logic power_down,
  input wire logic counter_load,
  input wire logic pump_up_n,
  input wire logic pump_down_n,
  input wire logic pump_source,
  input wire logic pump_sink,
  input wire logic lock_node,
  input wire logic lock_flag
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);
  src_follows_up_a: assert property (pump_source == !pump_up_n) else $error("source wrong");
  sink_follows_dn_a: assert property (pump_sink == !pump_down_n) else $error("sink wrong");
  node_is_nand_a: assert property (lock_node == !(pump_up_n && pump_down_n)) else $error("node wrong");
  one_pulse_a: assert property (pump_up_n || pump_down_n) else $error("both pulses");
  flag_drops_a: assert property (lock_node |=> !lock_flag) else $error("flag kept");
  flag_waits_a: assert property (lock_node ##1 (!lock_node)[*8] |-> !lock_flag) else $error("flag early");
  pd_blocks_a: assert property (power_down[*2] |-> pump_up_n && pump_down_n && !monitor_out)
    else $error("pd leak");
  gate_off_a: assert property (aux_gate_n[*5] |-> !power_down && !counter_load && !monitor_out)
    else $error("gate leak");
  load_not_pd_a: assert property (counter_load |-> !power_down) else $error("load in pd");
endmodule
bind pll_aux_pfd pll_aux_pfd_chk chk_u (
  .sys_clk(sys_clk),
  .srst(srst),
  .aux_gate_n(aux_gate_n),
  .monitor_out(monitor_out),
  .power_down(power_down),
  .counter_load(counter_load),
  .pump_up_n(pump_up_n),
  .pump_down_n(pump_down_n),
  .pump_source(pump_source),
  .pump_sink(pump_sink),
  .lock_node(lock_node),
  .lock_flag(lock_flag)
);

// ### test/tb_top.sv
// Testbench for pll_aux_pfd.
// Assumes host_model drives the serial pins.
`timescale 1ns/1ps
module tb_top;
  logic sys_clk = 0, srst = 1, main_wr = 0, aux_gate_n = 0;
  logic vco_div_pulse = 0, ref_div_pulse = 0, modulus_select = 0;
  logic ser_clk, ser_data, aux_wr, monitor_out, power_down, counter_load;
  logic pump_up_n, pump_down_n, pump_source, pump_sink, lock_node, lock_flag;
  logic [31:0] rng = 32'h0000_90ca;
  logic [8:0] tbl [9] = '{9'h004, 9'h008, 9'h010, 9'h020, 9'h040, 9'h083, 9'h064, 9'h160, 9'h0d8};
  logic [8:0] e;
  int error_cnt = 0, compares = 0;
  always #10 sys_clk = ~sys_clk;
  pll_aux_pfd dut_u (
    .sys_clk(sys_clk),
    .srst(srst),
    .ser_clk(ser_clk),
    .ser_data(ser_data),
    .aux_wr(aux_wr),
    .main_wr(main_wr),
    .aux_gate_n(aux_gate_n),
    .vco_div_pulse(vco_div_pulse),
    .ref_div_pulse(ref_div_pulse),
    .modulus_select(modulus_select),
    .monitor_out(monitor_out),
    .power_down(power_down),
    .counter_load(counter_load),
    .pump_up_n(pump_up_n),
    .pump_down_n(pump_down_n),
    .pump_source(pump_source),
    .pump_sink(pump_sink),
    .lock_node(lock_node),
    .lock_flag(lock_flag)
  );
  host_model host_u (
    .ser_clk(ser_clk),
    .ser_data(ser_data),
    .aux_wr(aux_wr)
  );
  function automatic logic [31:0] xs(logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  function automatic logic [2:0] exp_ctl(logic [8:0] a, logic v, logic m, logic r);
    logic on, pd;
    on = !a[8];
    pd = a[3] & on;
    return {pd, a[4] & on & !pd, on & !pd & (a[2] ? v : a[5] ? m : a[6] ? r : 1'b0)};
  endfunction
  task automatic check(string nm, logic [7:0] seen, logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic pfd(logic lead_ref, int d, int x);
    int n = 0;
    @(posedge sys_clk);
    if (lead_ref) ref_div_pulse <= 1;
    else vco_div_pulse <= 1;
    for (int j = 1; j <= d + 12; j++) begin
      @(posedge sys_clk);
      if (j == d) begin
        ref_div_pulse <= 1;
        vco_div_pulse <= 1;
      end
      @(negedge sys_clk);
      n += lead_ref ? !pump_up_n : !pump_down_n;
    end
    check("pulse_len", n[7:0], x[7:0]);
    ref_div_pulse <= 0;
    vco_div_pulse <= 0;
    repeat (24) @(posedge sys_clk);
    if (x != 0) check("lock_flag", lock_flag, 1);
  endtask
  task automatic test_done;
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #300000;
    error_cnt++;
    test_done;
  end
  initial begin
    repeat (10) @(posedge sys_clk);
    srst <= 0;
    @(negedge sys_clk);
    check("rst_out", {pump_up_n, pump_down_n, lock_flag, power_down}, 8'h0c);
    for (int i = 0; i < 13; i++) begin
      rng = xs(rng);
      e = i < 9 ? tbl[i] : rng[8:0];
      @(posedge sys_clk);
      aux_gate_n <= e[8];
      vco_div_pulse <= rng[9];
      modulus_select <= rng[10];
      ref_div_pulse <= rng[11];
      host_u.send(e[7:0]);
      @(negedge sys_clk);
      check("ctl", {power_down, counter_load, monitor_out}, exp_ctl(e, rng[9], rng[10], rng[11]));
    end
    @(posedge sys_clk);
    aux_gate_n <= 0;
    vco_div_pulse <= 0;
    ref_div_pulse <= 0;
    host_u.send(8'h08);
    main_wr <= 1;
    host_u.send(8'h10);
    @(negedge sys_clk);
    check("refused", {power_down, counter_load}, 8'h02);
    main_wr <= 0;
    pfd(1, 6, 0);
    host_u.send(8'h00);
    repeat (24) @(posedge sys_clk);
    for (int i = 0; i < 6; i++) begin
      rng = xs(rng);
      pfd(i[0], i == 0 ? 1 : 2 + rng[3:0], i == 0 ? 1 : 2 + rng[3:0]);
    end
    test_done;
  end
endmodule
